// File: hw/cbt_defs.vh
// Constants for the CAN bit-timing and interrupt-mask block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef CBT_DEFS_VH
`define CBT_DEFS_VH

// Register indices; the APB byte address is four times the index.
`define CBT_IDX_BIT_TIMING_FIRST  8'h00
`define CBT_IDX_BIT_TIMING_SECOND 8'h01
`define CBT_IDX_QUANTUM_PRESCALER 8'h03
`define CBT_IDX_IRQ_ENABLE_MASK   8'h0a
`define CBT_IDX_MODE_CTRL         8'h12
`define CBT_IDX_IRQ_FLAGS         8'h11

// Reset values.
`define CBT_RST_BIT_TIMING_FIRST  8'h00
`define CBT_RST_BIT_TIMING_SECOND 8'h00
`define CBT_RST_QUANTUM_PRESCALER 8'h00
`define CBT_RST_IRQ_ENABLE_MASK   8'h00
`define CBT_RST_MODE_CTRL         8'h01
`define CBT_RST_IRQ_FLAGS         8'h00

// First timing register fields.
`define CBT_SEG_ONE_LSB           0
`define CBT_SEG_ONE_MSB           3
`define CBT_SEG_TWO_LSB           4
`define CBT_SEG_TWO_MSB           6
`define CBT_THREE_POINT_BIT       7

// Second timing register fields and writable bits.
`define CBT_RESYNC_LSB            0
`define CBT_RESYNC_MSB            1
`define CBT_SYNC_EDGE_BIT         2
`define CBT_CMP_BYPASS_BIT        6
`define CBT_RX_INVERT_BIT         7
`define CBT_SECOND_WMASK          8'hc7

// Prescaler field and writable bits.
`define CBT_QDIV_MSB              5
`define CBT_QDIV_WMASK            8'h3f

// Mode register field.
`define CBT_INIT_MODE_BIT         0

// Bit-timing segment codes.
`define CBT_SEG_SYNC              2'h0
`define CBT_SEG_ONE               2'h1
`define CBT_SEG_TWO               2'h2

`endif

// File: hw/cbt_top.v
// CAN bit-timing, receive-input conditioning and interrupt-mask block.
// Assumes an APB master on clk, CAN event pulses from the protocol core
// and a receive input pair that is already synchronous to clk.
//
// Notes on behaviour
// R1: Mask bits gate only the interrupt pin, never the stored flags.
// R2: Mask bit 0 lets receive events drive the interrupt pin.
// R3: Mask bit 1 lets completed transmit jobs drive the interrupt pin.
// R4: Mask bit 2 lets the error warning level drive the interrupt pin.
// R5: Mask bit 3 lets remote frame reception drive the interrupt pin.
// R6: Mask bits 4 to 7 gate wake-up, bus-off, passive, tx-check; reset zero.
// R7: Segment one lasts its four-bit field plus one quanta.
// R8: Segment two lasts its three-bit field plus one quanta.
// R9: Bit 7 of the first timing register selects three samples per bit.
// R10: Resynchronisation jump is limited to its field plus one quanta.
// R11: Edge select zero uses falling edges only; one uses both edges.
// R12: Comparator bypass reads line a digitally and disables the comparator.
// R13: Receive invert bit flips the incoming bus level.
// R14: Software writes zero to every undefined timing and prescaler bit.
// R15: Timing registers accept writes only while init mode is set.
// R16: Prescaler is write-only and writable only in init mode.
// R17: A quantum lasts prescaler plus one times two clock periods.
// R18: A bit is sync quantum plus both segments.
// R19: Init mode enables configuration writes; zero runs normal operation.
// R20: Flags are set by their events whatever the mask says.
// R21: Interrupt pin stays high at least one bit time, drops when cleared.
//
// Register map.
// The bus index is the byte
// address divided by four.
// Only the low byte of each
// word carries data.
// Unmapped indices answer
// with an error and zero.
//
// Write gating.
// Both timing registers and
// the prescaler ignore writes
// while init mode is clear.
// No error is flagged then,
// so software must read back
// to see that a write landed.
//
// Undefined bits.
// Undefined timing bits are
// dropped on write, so stray
// ones from software do not
// change the bit timing.
//
// Prescaler.
// The prescaler reads as
// zero; keep a copy in
// software if it is needed.
//
// Interrupt flags.
// Events set flags whatever
// the mask holds. Writing a
// zero clears a flag, a one
// keeps it. An event in the
// same cycle as its clear
// wins, so nothing is lost.
//
// Interrupt pin.
// The pin rises two edges
// after an enabled event.
// It then holds for a whole
// bit time, so a slow host
// cannot miss a short one.
// It falls the cycle after
// all enabled flags clear.
//
// Bit engine.
// A quantum is two clocks
// times the divider plus one.
// A bit is one sync quantum
// and the two segments.
// The engine is held in its
// sync state in init mode,
// so new settings start on
// a clean bit boundary.
//
// Receive level.
// Without bypass, line a is
// compared with line b as
// plain logic levels. With
// bypass, line a alone is
// used. Inversion follows.
//
// Three-point read.
// The sample is a majority
// of three quantum ticks. It
// filters spikes but eats
// into the sample margin, so
// it suits slow rates only.
//
// Resynchronisation.
// Only one jump is taken in
// each bit, and it is capped
// by the jump limit field.
// A late edge stretches
// segment one; an early one
// shortens segment two.
//
// Outputs.
// Every output comes from a
// flip-flop, so downstream
// logic sees no glitches.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`include "cbt_defs.vh"

module cbt_top (
    input  wire        clk,           // 250 MHz clock, also the oscillator.
    input  wire        rst_n,         // Synchronous reset, active low.
    input  wire        psel,          // APB select.
    input  wire        penable,       // APB access phase.
    input  wire        pwrite,        // APB direction, high for write.
    input  wire [31:0] paddr,         // APB byte address.
    input  wire [31:0] pwdata,        // APB write data.
    output reg  [31:0] prdata,        // APB read data.
    output reg         pready,        // APB ready.
    output reg         pslverr,       // APB error for unmapped addresses.
    input  wire [7:0]  event_pulse,   // Event pulses in flag bit order.
    input  wire        rx_line_a,     // First receive line.
    input  wire        rx_line_b,     // Second receive line.
    output reg         irq,           // Interrupt pin, active high.
    output reg         rx_bit,        // Sampled bus bit, 1 is recessive.
    output reg         sample_strobe, // One-cycle pulse at the sample point.
    output reg         bit_start,     // One-cycle pulse at each bit start.
    output reg         init_active    // Copy of the init mode bit.
);

    reg  [7:0]  timing_first_ff;
    reg  [7:0]  timing_second_ff;
    reg  [7:0]  prescaler_ff;
    reg  [7:0]  mask_ff;
    reg  [7:0]  mode_ff;
    reg  [7:0]  flags_ff;
    reg  [6:0]  tq_cnt_ff;
    reg  [1:0]  seg_ff;
    reg  [4:0]  q_cnt_ff;
    reg  [4:0]  seg1_len_ff;
    reg  [1:0]  hist_ff;
    reg         prev_lvl_ff;
    reg         edge_pend_ff;
    reg         edge_used_ff;
    reg  [11:0] hold_cnt_ff;

    wire [7:0]  idx         = paddr[9:2];
    wire        setup       = psel & ~penable;
    wire        wr_done     = psel & penable & pready & pwrite;
    wire        init_mode   = mode_ff[`CBT_INIT_MODE_BIT];
    wire [3:0]  seg_one_len = timing_first_ff[`CBT_SEG_ONE_MSB:`CBT_SEG_ONE_LSB];
    wire [2:0]  seg_two_len = timing_first_ff[`CBT_SEG_TWO_MSB:`CBT_SEG_TWO_LSB];
    wire        three_point = timing_first_ff[`CBT_THREE_POINT_BIT];
    wire [1:0]  resync_lim  = timing_second_ff[`CBT_RESYNC_MSB:`CBT_RESYNC_LSB];
    wire        sync_edge_select  = timing_second_ff[`CBT_SYNC_EDGE_BIT];
    wire        comparator_bypass = timing_second_ff[`CBT_CMP_BYPASS_BIT];
    wire        rx_invert         = timing_second_ff[`CBT_RX_INVERT_BIT];
    wire [5:0]  quantum_divider   = prescaler_ff[`CBT_QDIV_MSB:0];

    // Address decode for the mapped register indices.
    wire        addr_ok = (paddr[31:10] == 22'h000000) &&
                          ((idx == `CBT_IDX_BIT_TIMING_FIRST)  ||
                           (idx == `CBT_IDX_BIT_TIMING_SECOND) ||
                           (idx == `CBT_IDX_QUANTUM_PRESCALER) ||
                           (idx == `CBT_IDX_IRQ_ENABLE_MASK)   ||
                           (idx == `CBT_IDX_MODE_CTRL)         ||
                           (idx == `CBT_IDX_IRQ_FLAGS));

    // Read multiplexer; the prescaler reads as zero.
    reg  [7:0]  rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (idx)
            `CBT_IDX_BIT_TIMING_FIRST:  rd_byte = timing_first_ff;
            `CBT_IDX_BIT_TIMING_SECOND: rd_byte = timing_second_ff;
            `CBT_IDX_QUANTUM_PRESCALER: rd_byte = 8'h00; // see R16
            `CBT_IDX_IRQ_ENABLE_MASK:   rd_byte = mask_ff;
            `CBT_IDX_MODE_CTRL:         rd_byte = mode_ff;
            `CBT_IDX_IRQ_FLAGS:         rd_byte = flags_ff;
            default:                    rd_byte = 8'h00;
        endcase
    end

    // APB answer: data and ready are prepared in the setup cycle, so the
    // access phase always completes in its first cycle without wait.
    always @(posedge clk) begin
        if (!rst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~addr_ok;
            if (setup) begin
                prdata <= (pwrite | ~addr_ok) ? 32'h00000000 : {24'h000000, rd_byte};
            end
        end
    end

    // Configuration writes; timing and prescaler only in init mode.
    wire        wr_ok = wr_done & addr_ok;
    always @(posedge clk) begin
        if (!rst_n) begin
            timing_first_ff  <= `CBT_RST_BIT_TIMING_FIRST;
            timing_second_ff <= `CBT_RST_BIT_TIMING_SECOND;
            prescaler_ff     <= `CBT_RST_QUANTUM_PRESCALER;
            mask_ff          <= `CBT_RST_IRQ_ENABLE_MASK; // see R6
            mode_ff          <= `CBT_RST_MODE_CTRL;
        end else if (wr_ok) begin
            if (idx == `CBT_IDX_BIT_TIMING_FIRST && init_mode) begin
                timing_first_ff <= pwdata[7:0]; // see R15 and R19
            end
            if (idx == `CBT_IDX_BIT_TIMING_SECOND && init_mode) begin
                // Undefined bits are dropped even if software ignores R14.
                timing_second_ff <= pwdata[7:0] & `CBT_SECOND_WMASK; // see R15
            end
            if (idx == `CBT_IDX_QUANTUM_PRESCALER && init_mode) begin
                prescaler_ff <= pwdata[7:0] & `CBT_QDIV_WMASK; // see R16
            end
            if (idx == `CBT_IDX_IRQ_ENABLE_MASK) begin
                mask_ff <= pwdata[7:0];
            end
            if (idx == `CBT_IDX_MODE_CTRL) begin
                mode_ff <= {7'h00, pwdata[`CBT_INIT_MODE_BIT]};
            end
        end
    end

    // Flags: events set regardless of mask; writing 0 clears, 1 keeps.
    // A set in the same cycle as a clear wins so no event is lost.
    wire [7:0]  clr_mask = (wr_ok && idx == `CBT_IDX_IRQ_FLAGS) ? ~pwdata[7:0] : 8'h00;
    always @(posedge clk) begin
        if (!rst_n) begin
            flags_ff <= `CBT_RST_IRQ_FLAGS;
        end else begin
            flags_ff <= (flags_ff & ~clr_mask) | event_pulse; // see R1 and R20
        end
    end

    // Bit time in clocks: 2*(divider+1)*(seg1+seg2+3), at most 3200.
    wire [11:0] bit_clocks = ({5'h00, quantum_divider + 7'h01} << 1) *
                             ({7'h00, seg_one_len} + {9'h000, seg_two_len} + 12'h003);

    // Interrupt pin: enabled flags raise it, it stays high for at least a
    // bit time and falls once all enabled flags are clear.
    wire        irq_req = |(flags_ff & mask_ff); // see R2 R3 R4 R5 R6
    always @(posedge clk) begin
        if (!rst_n) begin
            irq         <= 1'b0;
            hold_cnt_ff <= 12'h000;
        end else if (!irq) begin
            irq         <= irq_req;
            hold_cnt_ff <= bit_clocks - 12'h001; // see R21
        end else if (hold_cnt_ff != 12'h000) begin
            hold_cnt_ff <= hold_cnt_ff - 12'h001;
        end else begin
            irq <= irq_req; // see R21
        end
    end

    // Receive level: comparator of line a against line b, or line a alone
    // when bypassed, then optional inversion.
    wire        cmp_lvl = comparator_bypass ? rx_line_a : (rx_line_a & ~rx_line_b); // see R12
    wire        rx_lvl  = cmp_lvl ^ rx_invert; // see R13

    // Quantum tick every 2*(divider+1) clocks.
    wire        tq_tick = (tq_cnt_ff == {quantum_divider, 1'b1}); // see R17
    wire        fall    = prev_lvl_ff & ~rx_lvl;
    wire        any_edg = prev_lvl_ff ^ rx_lvl;
    wire        sync_edge = sync_edge_select ? any_edg : fall; // see R11

    // Edge tracking between quantum ticks; one resync per bit.
    always @(posedge clk) begin
        if (!rst_n) begin
            prev_lvl_ff  <= 1'b1;
            edge_pend_ff <= 1'b0;
        end else begin
            prev_lvl_ff  <= rx_lvl;
            if (tq_tick || init_mode) begin
                edge_pend_ff <= 1'b0;
            end else if (sync_edge && !edge_used_ff) begin
                edge_pend_ff <= 1'b1;
            end
        end
    end

    // Three-point read: two previous quanta plus the sample quantum.
    wire        majority = (hist_ff[0] & hist_ff[1]) | (hist_ff[0] & rx_lvl) |
                           (hist_ff[1] & rx_lvl);
    wire        sample_val = three_point ? majority : rx_lvl; // see R9
    wire [4:0]  jump     = {3'h0, resync_lim} + 5'h01; // see R10
    wire [4:0]  seg1_end = seg1_len_ff - 5'h01;
    wire [4:0]  seg2_len = {2'h0, seg_two_len} + 5'h01; // see R8
    wire [4:0]  seg2_left = seg2_len - q_cnt_ff;

    // Bit timing engine: sync quantum, segment one, segment two.
    // Held at the start of a bit while init mode is set.
    always @(posedge clk) begin
        if (!rst_n || init_mode) begin
            tq_cnt_ff     <= 7'h00;
            seg_ff        <= `CBT_SEG_SYNC;
            q_cnt_ff      <= 5'h00;
            seg1_len_ff   <= 5'h01;
            hist_ff       <= 2'h3;
            edge_used_ff  <= 1'b0;
            rx_bit        <= 1'b1;
            sample_strobe <= 1'b0;
            bit_start     <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            bit_start     <= 1'b0;
            tq_cnt_ff     <= tq_tick ? 7'h00 : tq_cnt_ff + 7'h01;
            if (tq_tick) begin
                hist_ff <= {hist_ff[0], rx_lvl};
                case (seg_ff)
                    `CBT_SEG_SYNC: begin
                        seg_ff      <= `CBT_SEG_ONE; // see R18
                        q_cnt_ff    <= 5'h00;
                        seg1_len_ff <= {1'b0, seg_one_len} + 5'h01; // see R7
                    end
                    `CBT_SEG_ONE: begin
                        if (edge_pend_ff) begin
                            // Late edge: stretch segment one by the error,
                            // clipped to the jump limit.
                            seg1_len_ff  <= seg1_len_ff +
                                            ((q_cnt_ff + 5'h01 < jump) ? q_cnt_ff + 5'h01
                                                                       : jump); // see R10
                            edge_used_ff <= 1'b1;
                            q_cnt_ff     <= q_cnt_ff + 5'h01;
                        end else if (q_cnt_ff >= seg1_end) begin
                            seg_ff        <= `CBT_SEG_TWO;
                            q_cnt_ff      <= 5'h00;
                            rx_bit        <= sample_val;
                            sample_strobe <= 1'b1;
                        end else begin
                            q_cnt_ff <= q_cnt_ff + 5'h01;
                        end
                    end
                    `CBT_SEG_TWO: begin
                        if (edge_pend_ff && seg2_left <= jump) begin
                            // Early edge close to the end: it becomes the
                            // sync of the next bit.
                            seg_ff       <= `CBT_SEG_ONE;
                            q_cnt_ff     <= 5'h00;
                            seg1_len_ff  <= {1'b0, seg_one_len} + 5'h01;
                            edge_used_ff <= 1'b0;
                            bit_start    <= 1'b1;
                        end else if (edge_pend_ff) begin
                            // Far early edge: shorten by the jump limit only.
                            q_cnt_ff     <= q_cnt_ff + jump;
                            edge_used_ff <= 1'b1;
                        end else if (q_cnt_ff + 5'h01 >= seg2_len) begin
                            seg_ff       <= `CBT_SEG_SYNC;
                            edge_used_ff <= 1'b0;
                            bit_start    <= 1'b1;
                        end else begin
                            q_cnt_ff <= q_cnt_ff + 5'h01;
                        end
                    end
                    default: begin
                        seg_ff <= `CBT_SEG_SYNC;
                    end
                endcase
            end
        end
    end

    // Init mode is mirrored for the protocol core.
    always @(posedge clk) begin
        if (!rst_n) begin
            init_active <= 1'b1;
        end else begin
            init_active <= init_mode; // see R19
        end
    end

endmodule

// File: tb/cbt_top_properties.sv
// Checker for the CAN bit-timing and interrupt-mask block.
// Assumes it is bound to cbt_top and sees only that module's ports.
`timescale 1ns/100ps
module cbt_props (
    input wire        clk,           // Clock.
    input wire        rst_n,         // Reset, active low.
    input wire        psel,          // APB select.
    input wire        penable,       // APB enable.
    input wire        pwrite,        // APB direction.
    input wire [31:0] paddr,         // APB address.
    input wire [31:0] pwdata,        // APB write data.
    input wire [31:0] prdata,        // APB read data.
    input wire        pready,        // APB ready.
    input wire        pslverr,       // APB error.
    input wire [7:0]  event_pulse,   // Event pulses.
    input wire        rx_line_a,     // Receive line a.
    input wire        rx_line_b,     // Receive line b.
    input wire        irq,           // Interrupt pin.
    input wire        rx_bit,        // Sampled bit.
    input wire        sample_strobe, // Sample point pulse.
    input wire        bit_start,     // Bit start pulse.
    input wire        init_active    // Init mode copy.
);
    wire [29:0] widx = paddr[31:2];
    wire        wr_done = psel && penable && pready && pwrite;
    wire        rd_done = psel && penable && pready && !pwrite;
    wire        mapped = widx == 0 || widx == 1 || widx == 3 || widx == 10 || widx == 17
                         || widx == 18;
    reg  [7:0]  msk_ff;
    reg  [7:0]  bt1_ff;
    reg  [5:0]  pre_ff;
    reg         md_ff;
    reg  [15:0] hcnt_ff;
    wire [15:0] bclk = 16'h0002 * (pre_ff + 16'h0001) * (bt1_ff[3:0] + bt1_ff[6:4] + 16'h0003);

    // Mirror of what software configured, so reads and hold times can be predicted.
    always @(posedge clk) begin
        if (!rst_n) begin
            msk_ff  <= 8'h00;
            bt1_ff  <= 8'h00;
            pre_ff  <= 6'h00;
            md_ff   <= 1'b1;
            hcnt_ff <= 16'h0000;
        end else begin
            if (wr_done && widx == 30'h0a) msk_ff <= pwdata[7:0];
            if (wr_done && widx == 30'h12) md_ff <= pwdata[0];
            if (wr_done && md_ff && widx == 30'h00) bt1_ff <= pwdata[7:0];
            if (wr_done && md_ff && widx == 30'h03) pre_ff <= pwdata[5:0];
            hcnt_ff <= irq ? hcnt_ff + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ack;
        pready ##1 !pready;
    endsequence

    a_ready_zero_wait: assert property (s_setup |=> s_ack)
        else $error("pready not one cycle after setup");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_prescaler_hidden: assert property (rd_done && widx == 3 |-> prdata == 32'h0)
        else $error("prescaler read not zero");
    a_mask_readback: assert property (rd_done && widx == 10 |-> prdata == {24'h0, msk_ff})
        else $error("mask read wrong");
    a_timing_gate: assert property (rd_done && widx == 0 |-> prdata[7:0] == bt1_ff)
        else $error("timing register took a locked write");
    a_irq_enabled: assert property ((event_pulse & msk_ff) != 8'h00 |-> ##2 irq)
        else $error("enabled event did not raise irq");
    a_irq_hold: assert property ($fell(irq) |-> hcnt_ff >= bclk)
        else $error("irq shorter than one bit");
    a_strobe_single: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");
    a_start_single: assert property (bit_start |=> !bit_start)
        else $error("bit start longer than one cycle");
    a_init_quiet: assert property (init_active && $past(init_active) |-> !sample_strobe && !bit_start)
        else $error("bit engine ran in init mode");
    a_rx_at_sample: assert property ($changed(rx_bit) |-> sample_strobe || init_active)
        else $error("rx bit changed off the sample point");
    a_init_copy: assert property (init_active == $past(md_ff))
        else $error("init copy wrong");
endmodule

bind cbt_top cbt_props cbt_props_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_pulse(event_pulse), .rx_line_a(rx_line_a),
    .rx_line_b(rx_line_b), .irq(irq), .rx_bit(rx_bit), .sample_strobe(sample_strobe),
    .bit_start(bit_start), .init_active(init_active));

// File: tb/cbt_bus_model.sv
// Bus side model: turns a bus level into the two receive lines.
// Assumes the bench sets the level only while the bit engine is held.
`timescale 1ns/100ps
module cbt_bus_model (
    input  wire dominant,  // Bus level, high is dominant.
    input  wire digital,   // Comparator bypass in use.
    output wire rx_line_a, // First receive line.
    output wire rx_line_b  // Second receive line.
);
    // Line a carries the digital level; line b is grounded when bypassed.
    assign rx_line_a = !dominant;
    assign rx_line_b = digital ? 1'b0 : dominant;
endmodule

// File: tb/tb_cbt_top.sv
// Self-checking bench for cbt_top over APB with a bus-side model.
// Assumes the bound checker and a 250 MHz clock.
`timescale 1ns/100ps
module tb_cbt_top;
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, dom = 0, dig = 0;
    logic [31:0] paddr = 0, pwdata = 0, rd;
    logic [7:0]  ev = 0;
    logic        er;
    wire  [31:0] prdata;
    wire         pready, pslverr, rx_a, rx_b, irq, rx_bit, smp, bst, init_act;
    int          n_mismatch = 0, check_count = 0;
    cbt_top cbt_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_pulse(ev), .rx_line_a(rx_a), .rx_line_b(rx_b),
        .irq(irq), .rx_bit(rx_bit), .sample_strobe(smp), .bit_start(bst),
        .init_active(init_act));
    cbt_bus_model cbt_bus_model_inst (.dominant(dom), .digital(dig), .rx_line_a(rx_a),
        .rx_line_b(rx_b));
    // Free-running clock, 4 ns period.
    initial forever #2 clk = ~clk;
    task check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [31:0] a, d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // Outputs are looked at mid-cycle, where they stand until the next edge.
        do begin
            @(negedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        check("pready", pready, 1);
        rd = prdata;
        er = pslverr;
        @(posedge clk);
        psel <= 0;
        penable <= 0;
    endtask
    task rdc(input string nm, input logic [31:0] a, exp, e);
        apb(0, a, 0);
        check(nm, rd, exp);
        check("pslverr", er, e);
    endtask
    // Counts edges until the chosen pulse is seen: 1 bit start, 0 sample point.
    task cnt(output int n, input logic sel);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((sel ? bst : smp) !== 1'b1 && n < 3000);
    endtask
    task pulse(input logic [7:0] x);
        @(posedge clk);
        ev <= x;
        @(posedge clk);
        ev <= 0;
        repeat (2) @(posedge clk);
    endtask
    task t_regs;
        rdc("bt1", 32'h00, 0, 0);
        rdc("bt2", 32'h04, 0, 0);
        rdc("pre", 32'h0c, 0, 0);
        rdc("mask", 32'h28, 0, 0);
        rdc("mode", 32'h48, 1, 0);
        rdc("flags", 32'h44, 0, 0);
        rdc("hole", 32'h3fc, 0, 1);
        apb(1, 32'h04, 32'hff);
        rdc("bt2_undef", 32'h04, 32'hc7, 0);
        apb(1, 32'h48, 0);
        apb(1, 32'h00, 32'h55);
        rdc("bt1_locked", 32'h00, 0, 0);
        apb(1, 32'h48, 1);
        apb(1, 32'h04, 0);
        $display("test regs done");
    endtask
    // Each mask bit alone: first the next event up, which must stay masked, then its own event.
    task t_irq;
        int i, k;
        for (i = 0; i < 8; i++) begin
            apb(1, 32'h28, 32'h1 << i);
            pulse(8'h1 << ((i + 1) % 8));
            check("irq_masked", irq, 0);
            rdc("flag_masked", 32'h44, 32'h1 << ((i + 1) % 8), 0);
            pulse(8'h1 << i);
            check("irq_on", irq, 1);
            apb(1, 32'h44, 0);
            k = 0;
            while (irq !== 1'b0 && k < 40) begin
                @(posedge clk);
                k++;
            end
            check("irq_off", irq, 0);
            rdc("flag_clr", 32'h44, 0, 0);
        end
        $display("test irq done");
    endtask
    // Segment two and whole bit lengths measured between engine pulses.
    task t_timing;
        logic [7:0] b1 [2] = '{8'h23, 8'h7f};
        logic [5:0] pr [2] = '{6'h00, 6'h02};
        int i, n, q;
        for (i = 0; i < 2; i++) begin
            apb(1, 32'h48, 1);
            apb(1, 32'h00, b1[i]);
            apb(1, 32'h0c, pr[i]);
            apb(1, 32'h48, 0);
            q = 2 * (pr[i] + 1);
            cnt(n, 1);
            cnt(n, 0);
            cnt(n, 1);
            check("seg_two", n, q * (b1[i][6:4] + 1));
            cnt(n, 1);
            check("bit_len", n, q * (b1[i][3:0] + b1[i][6:4] + 3));
        end
        $display("test timing done");
    endtask
    // Receive level through comparator, bypass, inversion and three-point modes.
    task t_rx;
        logic [18:0] tab [5] = '{{8'h23, 8'h00, 3'b100}, {8'h23, 8'h80, 3'b101},
            {8'h23, 8'h40, 3'b110}, {8'h23, 8'hc0, 3'b010}, {8'ha3, 8'h04, 3'b100}};
        int i, n;
        for (i = 0; i < 5; i++) begin
            apb(1, 32'h48, 1);
            dom <= tab[i][2];
            dig <= tab[i][1];
            apb(1, 32'h00, tab[i][18:11]);
            apb(1, 32'h04, tab[i][10:3]);
            apb(1, 32'h48, 0);
            cnt(n, 0);
            cnt(n, 0);
            check("rx_bit", rx_bit, tab[i][0]);
        end
        $display("test rx done");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence after a four-cycle reset.
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_regs;
        t_irq;
        t_timing;
        t_rx;
        tally_and_finish;
    end
    // Watchdog well beyond the some 1200 cycles the tests need.
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule
